/* hdl/rpc_defines.vh */
// constants for the repeater port id and csi register slice
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH
// ====================================================
// main bank byte offsets (index; byte address is index*4)
`define RPC_IDX_PORT1 8'he1
`define RPC_IDX_PORT2 8'he2
`define RPC_IDX_PORT3 8'he3
`define RPC_IDX_ID0 8'hf0
`define RPC_IDX_ID1 8'hf1
`define RPC_IDX_ID2 8'hf2
`define RPC_IDX_ID3 8'hf3
`define RPC_IDX_ID4 8'hf4
`define RPC_IDX_ID5 8'hf5
// ====================================================
// csi indirect bank offsets
`define RPC_IDX_TRAIL 8'h02
`define RPC_IDX_RAW 8'h09
`define RPC_IDX_CSIEN_A 8'h13
`define RPC_IDX_CSIEN_B 8'h14
`define RPC_IDX_PASS 8'h16
`define RPC_IDX_VC 8'h2e
// ====================================================
// field positions and masks
`define RPC_TRAIL_OVR_BIT 7
`define RPC_TRAIL_WMASK 8'h8f
`define RPC_RAW_BIT 4
`define RPC_RAW_WMASK 8'h10
`define RPC_TRAIL_VAL_HI 3
`define RPC_TRAIL_VAL_LO 0
`define RPC_EN_HI 5
`define RPC_EN_LO 0
`define RPC_VC_HI 7
`define RPC_VC_LO 6
`define RPC_RDATA_PAD 24'h000000
// ====================================================
// discovery select codes for entries one to three
`define RPC_SEL_PORT1 2'h1
`define RPC_SEL_PORT2 2'h2
`define RPC_SEL_PORT3 2'h3
// ====================================================
// reset values
`define RPC_RST_ZERO 8'h00
`define RPC_RST_CSIEN_A 8'h3f
`define RPC_RST_CSIEN_B 8'h00
`define RPC_RST_PASS 8'h02
`define RPC_RST_VC 8'h00
`define RPC_RST_RDATA 32'h00000000
`define RPC_RST_EN 6'h00
`define RPC_RST_VCSEL 2'h0
// ====================================================
// bus address layout: bit 10 picks the csi bank, bits 9:2 the index
`define RPC_BANK_BIT 10
`define RPC_IDX_HI 9
`define RPC_IDX_LO 2
`endif

/* hdl/rpc_port_entry.v */
// one downstream port entry: address and present flag, loaded by discovery
`timescale 1ns/1ps
module rpc_port_entry
(
    input wire clk_sys,
    input wire rst_n,
    input wire loadStb,
    input wire [6:0] loadAddr,
    input wire loadPresent,
    output wire [7:0] entryValue
);
`include "rpc_defines.vh"
reg [7:0] entry_q;
// ====================================================
// storage
always @(posedge clk_sys)
begin
    if (!rst_n)
        entry_q <= `RPC_RST_ZERO;
    else if (loadStb)
        entry_q <= {loadAddr, loadPresent};
end
assign entryValue = entry_q;
endmodule // rpc_port_entry

/* hdl/rpc_regs.v */
// repeater port id and csi register slice behind an apb slave
//
// Notes on behaviour
// - port entry upper seven bits report downstream port bus address, read only
// - port entry bit zero is read-only present flag for that address
// - three entries for ports one to three, consecutive, reset to zero
// - six read-only id bytes at consecutive offsets, fixed values
// - third id byte shows one of two values, cipher present or not
// - read-only fields ignore writes; read/write fields store and read back
// - trail override bit clear selects automatic trail interval, resets zero
// - override bit set selects the low four bits as trail interval
// - raw align bit picks lsb or msb placement on pixel bus, resets zero
`timescale 1ns/1ps
module rpc_regs
#(
    parameter [7:0] ID_BYTE0 = 8'h41, // arbitrary
    parameter [7:0] ID_BYTE1 = 8'h42, // arbitrary
    parameter [7:0] ID_BYTE2_WITH = 8'h43, // arbitrary
    parameter [7:0] ID_BYTE2_WITHOUT = 8'h44, // arbitrary
    parameter [7:0] ID_BYTE3 = 8'h45, // arbitrary
    parameter [7:0] ID_BYTE4 = 8'h46, // arbitrary
    parameter [7:0] ID_BYTE5 = 8'h47, // arbitrary
    parameter HAS_CIPHER = 1,
    parameter [3:0] AUTO_TRAIL = 4'h5,
    parameter RAW_WIDTH = 12,
    parameter BUS_WIDTH = 24
)
(
    input wire clk_sys,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] discSel,
    input wire discStb,
    input wire [6:0] discAddr,
    input wire discPresent,
    input wire [RAW_WIDTH-1:0] rawPixel,
    output reg [BUS_WIDTH-1:0] pixelBus_q,
    output reg [3:0] trailInterval_q,
    output reg [5:0] csiEnableA_q,
    output reg [5:0] csiEnableB_q,
    output reg [1:0] virtualChannel_q
);
`include "rpc_defines.vh"
// ====================================================
// apb decode
wire csiBank = paddr[`RPC_BANK_BIT];
wire [7:0] idx = paddr[`RPC_IDX_HI:`RPC_IDX_LO];
wire setup = psel && !penable;
wire doWrite = psel && penable && pready && pwrite;
wire [7:0] wrByte = pwdata[7:0];
reg [7:0] rdByte;
reg hit;
wire [7:0] trailVal;
wire [7:0] rawVal;
wire [7:0] enAVal;
wire [7:0] enBVal;
wire [7:0] passVal;
wire [7:0] vcVal;
wire [7:0] ent1;
wire [7:0] ent2;
wire [7:0] ent3;
wire [7:0] idByte2 = HAS_CIPHER ? ID_BYTE2_WITH : ID_BYTE2_WITHOUT;
localparam PAD_WIDTH = BUS_WIDTH - RAW_WIDTH;
reg [7:0] csiByte;
reg csiHit;
reg [7:0] mainByte;
reg mainHit;
// ====================================================
// write and load strobes; an unmapped index raises no strobe, so the write is dropped
// loads come only from discovery; software has no write path into the entries
wire wrTrail = doWrite && csiBank && (idx == `RPC_IDX_TRAIL);
wire wrRaw = doWrite && csiBank && (idx == `RPC_IDX_RAW);
wire wrEnA = doWrite && csiBank && (idx == `RPC_IDX_CSIEN_A);
wire wrEnB = doWrite && csiBank && (idx == `RPC_IDX_CSIEN_B);
wire wrPass = doWrite && csiBank && (idx == `RPC_IDX_PASS);
wire wrVc = doWrite && csiBank && (idx == `RPC_IDX_VC);
wire loadEnt1 = discStb && (discSel == `RPC_SEL_PORT1);
wire loadEnt2 = discStb && (discSel == `RPC_SEL_PORT2);
wire loadEnt3 = discStb && (discSel == `RPC_SEL_PORT3);
// ====================================================
// next values of the registered outputs
reg pready_d;
reg pslverr_d;
reg [31:0] prdata_d;
reg [3:0] trailInterval_d;
reg [BUS_WIDTH-1:0] pixelBus_d;
reg [5:0] csiEnableA_d;
reg [5:0] csiEnableB_d;
reg [1:0] virtualChannel_d;
// ====================================================
// downstream port entries, loaded by the discovery logic only
rpc_port_entry uEnt1
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .loadStb(loadEnt1),
    .loadAddr(discAddr),
    .loadPresent(discPresent),
    .entryValue(ent1)
);
// ====================================================
// entry for port two
rpc_port_entry uEnt2
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .loadStb(loadEnt2),
    .loadAddr(discAddr),
    .loadPresent(discPresent),
    .entryValue(ent2)
);
// ====================================================
// entry for port three
rpc_port_entry uEnt3
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .loadStb(loadEnt3),
    .loadAddr(discAddr),
    .loadPresent(discPresent),
    .entryValue(ent3)
);
// ====================================================
// csi indirect registers: clock trail timing
rpc_rw_reg #(.RESET_VAL(`RPC_RST_ZERO), .WMASK(`RPC_TRAIL_WMASK)) uTrail
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrTrail),
    .wrData(wrByte),
    .regValue(trailVal)
);
// ====================================================
// raw pixel placement; only the align bit is stored
rpc_rw_reg #(.RESET_VAL(`RPC_RST_ZERO), .WMASK(`RPC_RAW_WMASK)) uRaw
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrRaw),
    .wrData(wrByte),
    .regValue(rawVal)
);
// ====================================================
// output enable, first port
rpc_rw_reg #(.RESET_VAL(`RPC_RST_CSIEN_A)) uEnA
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrEnA),
    .wrData(wrByte),
    .regValue(enAVal)
);
// ====================================================
// output enable, second port
rpc_rw_reg #(.RESET_VAL(`RPC_RST_CSIEN_B)) uEnB
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrEnB),
    .wrData(wrByte),
    .regValue(enBVal)
);
// ====================================================
// pass routing; the status bit is stored, not live
rpc_rw_reg #(.RESET_VAL(`RPC_RST_PASS)) uPass
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrPass),
    .wrData(wrByte),
    .regValue(passVal)
);
// ====================================================
// virtual channel select
rpc_rw_reg #(.RESET_VAL(`RPC_RST_VC)) uVc
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrStb(wrVc),
    .wrData(wrByte),
    .regValue(vcVal)
);
// ====================================================
// read mux, split by bank; main bank is read-only so writes there change nothing
always @*
begin
    csiByte = `RPC_RST_ZERO;
    csiHit = 1'h1;
    case (idx)
        `RPC_IDX_TRAIL: csiByte = trailVal;
        `RPC_IDX_RAW: csiByte = rawVal;
        `RPC_IDX_CSIEN_A: csiByte = enAVal;
        `RPC_IDX_CSIEN_B: csiByte = enBVal;
        `RPC_IDX_PASS: csiByte = passVal;
        `RPC_IDX_VC: csiByte = vcVal;
        default: csiHit = 1'h0;
    endcase
end
always @*
begin
    mainByte = `RPC_RST_ZERO;
    mainHit = 1'h1;
    case (idx)
        `RPC_IDX_PORT1: mainByte = ent1;
        `RPC_IDX_PORT2: mainByte = ent2;
        `RPC_IDX_PORT3: mainByte = ent3;
        `RPC_IDX_ID0: mainByte = ID_BYTE0;
        `RPC_IDX_ID1: mainByte = ID_BYTE1;
        `RPC_IDX_ID2: mainByte = idByte2;
        `RPC_IDX_ID3: mainByte = ID_BYTE3;
        `RPC_IDX_ID4: mainByte = ID_BYTE4;
        `RPC_IDX_ID5: mainByte = ID_BYTE5;
        default: mainHit = 1'h0;
    endcase
end
// ====================================================
// bank select; an unmapped index reads zero and answers with an error
always @*
begin
    if (csiBank)
    begin
        rdByte = csiByte;
        hit = csiHit;
    end
    else
    begin
        rdByte = mainByte;
        hit = mainHit;
    end
end
// ====================================================
// apb ready and error: no wait states, ready pulses in the first access cycle, error with it only on an unmapped index
always @*
begin
    pready_d = setup;
    pslverr_d = setup && !hit;
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        pready <= 1'h0;
    else
        pready <= pready_d;
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        pslverr <= 1'h0;
    else
        pslverr <= pslverr_d;
end
// ====================================================
// read data is captured at setup and then held, so it still stands at the ready edge
always @*
begin
    prdata_d = prdata;
    if (setup && !pwrite)
        prdata_d = {`RPC_RDATA_PAD, rdByte};
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        prdata <= `RPC_RST_RDATA;
    else
        prdata <= prdata_d;
end
// ====================================================
// clock-lane trail interval; automatic value unless the override is set
// the register is read every cycle, so a new setting reaches trailInterval_q two cycles after the accepted write
always @*
begin
    if (trailVal[`RPC_TRAIL_OVR_BIT])
        trailInterval_d = trailVal[`RPC_TRAIL_VAL_HI:`RPC_TRAIL_VAL_LO];
    else
        trailInterval_d = AUTO_TRAIL;
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        trailInterval_q <= AUTO_TRAIL;
    else
        trailInterval_q <= trailInterval_d;
end
// ====================================================
// raw pixel placement; the unused bits of the bus are driven low
always @*
begin
    if (rawVal[`RPC_RAW_BIT])
        pixelBus_d = {rawPixel, {PAD_WIDTH{1'h0}}};
    else
        pixelBus_d = {{PAD_WIDTH{1'h0}}, rawPixel};
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        pixelBus_q <= {BUS_WIDTH{1'h0}};
    else
        pixelBus_q <= pixelBus_d;
end
// ====================================================
// port enables; the register-control bit is not used by this slice
always @*
begin
    csiEnableA_d = enAVal[`RPC_EN_HI:`RPC_EN_LO];
end
always @*
begin
    csiEnableB_d = enBVal[`RPC_EN_HI:`RPC_EN_LO];
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        csiEnableA_q <= `RPC_RST_EN;
    else
        csiEnableA_q <= csiEnableA_d;
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        csiEnableB_q <= `RPC_RST_EN;
    else
        csiEnableB_q <= csiEnableB_d;
end
// ====================================================
// virtual channel number
always @*
begin
    virtualChannel_d = vcVal[`RPC_VC_HI:`RPC_VC_LO];
end
always @(posedge clk_sys)
begin
    if (!rst_n)
        virtualChannel_q <= `RPC_RST_VCSEL;
    else
        virtualChannel_q <= virtualChannel_d;
end
endmodule // rpc_regs

/* hdl/rpc_rw_reg.v */
// one masked read/write byte register
`timescale 1ns/1ps
module rpc_rw_reg
#(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WMASK = 8'hff
)
(
    input wire clk_sys,
    input wire rst_n,
    input wire wrStb,
    input wire [7:0] wrData,
    output wire [7:0] regValue
);
reg [7:0] reg_q;
// ====================================================
// storage; masked-off bits stay at their reset value
always @(posedge clk_sys)
begin
    if (!rst_n)
        reg_q <= RESET_VAL;
    else if (wrStb)
        reg_q <= (wrData & WMASK) | (RESET_VAL & ~WMASK);
end
assign regValue = reg_q;
endmodule // rpc_rw_reg

/* test/rpc_regs_asserts.sv */
// assertion checker for the repeater port id and csi register slice
`timescale 1ns/1ps
module rpc_regs_asserts
#(
    parameter RAW_WIDTH = 12,
    parameter BUS_WIDTH = 24,
    parameter [3:0] AUTO_TRAIL = 4'h5
)
(
    input wire clk_sys,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] discSel,
    input wire discStb,
    input wire [6:0] discAddr,
    input wire discPresent,
    input wire [RAW_WIDTH-1:0] rawPixel,
    input wire [BUS_WIDTH-1:0] pixelBus_q,
    input wire [3:0] trailInterval_q,
    input wire [5:0] csiEnableA_q,
    input wire [5:0] csiEnableB_q,
    input wire [1:0] virtualChannel_q
);
    // ========
    // handshake and trail timing
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // accepted write to the trail register in the csi bank
    wire wrTrail = psel && penable && pready && pwrite && paddr[10:2] == 9'h102;
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_error_in_access: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    chk_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data set");
    chk_id_mapped: assert property (pready && paddr[10:2] == 9'h0f5 |-> !pslverr)
        else $error("id byte refused");
    chk_trail_auto: assert property (wrTrail && !pwdata[7]
        |=> ##1 trailInterval_q == AUTO_TRAIL) else $error("auto trail not used");
    chk_trail_override: assert property (wrTrail && pwdata[7]
        |=> ##1 trailInterval_q == $past(pwdata[3:0], 2)) else $error("override unused");
    chk_trail_quiet: assert property ($changed(trailInterval_q)
        |-> $past(wrTrail) || $past(wrTrail, 2)) else $error("trail moved alone");
    cover property (wrTrail && pwdata[7]);
    cover property (pslverr);
    cover property (pready && !pwrite);
endmodule // rpc_regs_asserts
bind rpc_regs rpc_regs_asserts #(.RAW_WIDTH(RAW_WIDTH), .BUS_WIDTH(BUS_WIDTH),
    .AUTO_TRAIL(AUTO_TRAIL)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .discSel(discSel), .discStb(discStb),
    .discAddr(discAddr), .discPresent(discPresent), .rawPixel(rawPixel),
    .pixelBus_q(pixelBus_q), .trailInterval_q(trailInterval_q), .csiEnableA_q(csiEnableA_q),
    .csiEnableB_q(csiEnableB_q), .virtualChannel_q(virtualChannel_q));

/* test/rpc_regs_tb_top.sv */
// self-checking bench for the repeater port id and csi register slice
`timescale 1ns/1ps
module rpc_regs_tb_top;
    // ========
    // signals and reference model
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, discStb, discPresent, err;
    logic [11:0] paddr, rawPixel;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] discSel, virtualChannel_q;
    logic [6:0] discAddr;
    logic [23:0] pixelBus_q;
    logic [3:0] trailInterval_q;
    logic [5:0] csiEnableA_q, csiEnableB_q;
    logic [7:0] mdl [int];
    // key is bank*256+index; the last two are unmapped on purpose
    int keys[$] = '{'he1, 'he2, 'he3, 'hf0, 'hf1, 'hf2, 'hf3, 'hf4, 'hf5,
        'h102, 'h109, 'h113, 'h114, 'h116, 'h12e, 'h103, 'he4};
    int rv[$] = '{0, 0, 0, 'h41, 'h42, 'h43, 'h45, 'h46, 'h47, 0, 0, 'h3f, 0, 2, 0};
    int num_errors = 0;
    int samples_checked = 0;
    int k, s;
    rpc_regs dut
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .discSel(discSel), .discStb(discStb), .discAddr(discAddr), .discPresent(discPresent),
        .rawPixel(rawPixel), .pixelBus_q(pixelBus_q), .trailInterval_q(trailInterval_q),
        .csiEnableA_q(csiEnableA_q), .csiEnableB_q(csiEnableB_q),
        .virtualChannel_q(virtualChannel_q)
    );
    initial
    begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ========
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one apb transfer, then an idle cycle so the next setup never collides
    task automatic xfer(input logic w, input int key, input logic [7:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= {1'b0, key[8], key[7:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            num_errors++;
            stop_test;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task chk_out;
        check(trailInterval_q, mdl['h102][7] ? mdl['h102][3:0] : 4'h5);
        check(pixelBus_q, mdl['h109][4] ? {rawPixel, 12'h0} : {12'h0, rawPixel});
        check({csiEnableB_q, csiEnableA_q, virtualChannel_q},
            {mdl['h114][5:0], mdl['h113][5:0], mdl['h12e][7:6]});
    endtask
    // ========
    // main sequence
    initial
    begin
        {rst_n, psel, penable, pwrite, discStb, discPresent} = '0;
        {paddr, pwdata, rawPixel, discSel, discAddr} = '0;
        void'($urandom(32'h2e12d3e2));
        foreach (rv[i]) mdl[keys[i]] = rv[i];
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        foreach (keys[i])
        begin
            xfer(0, keys[i], 0);
            if (mdl.exists(keys[i])) check(rd, mdl[keys[i]]);
            check(err, !mdl.exists(keys[i]));
        end
        chk_out;
        // random mix of writes, discovery loads and read-backs
        repeat (150)
        begin
            k = keys[$urandom % keys.size()];
            rawPixel <= 12'($urandom);
            if ($urandom % 4 == 0)
            begin
                s = $urandom % 4;
                k = 'he0 + (s == 0 ? 1 : s);
                discSel <= 2'(s);
                discAddr <= 7'($urandom);
                discPresent <= 1'($urandom);
                discStb <= 1;
                @(posedge clk_sys);
                discStb <= 0;
                if (s != 0) mdl[k] = {discAddr, discPresent};
            end
            else
            begin
                s = $urandom;
                xfer(1, k, s[7:0]);
                check(err, !mdl.exists(k));
                if (k > 'hff && mdl.exists(k))
                    mdl[k] = s[7:0] & (k == 'h102 ? 8'h8f : k == 'h109 ? 8'h10 : 8'hff);
            end
            xfer(0, k, 0);
            if (mdl.exists(k)) check(rd, mdl[k]);
            chk_out;
        end
        stop_test;
    end
endmodule // rpc_regs_tb_top
